// file: rtl/fid_pkg.sv
// Package for the flash control and identification register bank.
// Holds the offsets, the reset values, the field positions and the access carriers.
// Assumes one 20 MHz system clock with an active-low asynchronous reset.
package fid_pkg;

  // ==========================================================================
  // Internal memory bus map, one 16-bit word per entry
  localparam int NUM_FLASH_REGS = 15;
  localparam int IDX_CONTROL_0_LOW    = 0;
  localparam int IDX_DATA_0_LOW       = 4;
  localparam int IDX_ERROR_FLAGS      = 10;
  localparam int IDX_NV_ACCESS_PROT_0 = 12;
  localparam logic [23:0] FLASH_REG_OFFSET [NUM_FLASH_REGS] = '{
    24'h080000,  // control_0_low
    24'h080002,  // control_0_high
    24'h080004,  // control_1_low
    24'h080006,  // control_1_high
    24'h080008,  // data_0_low
    24'h08000a,  // data_0_high
    24'h08000c,  // data_1_low
    24'h08000e,  // data_1_high
    24'h080010,  // target_address_low
    24'h080012,  // target_address_high
    24'h080014,  // error_flags
    24'h08dfb0,  // nv_write_protect_1
    24'h08dfb8,  // nv_access_protect_0
    24'h08dfbc,  // nv_access_protect_1_low
    24'h08dfbe   // nv_access_protect_1_high
  };
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_DATA      = 16'hffff;
  localparam logic [15:0] RST_NV_ONES   = 16'hffff;
  localparam logic [15:0] RST_NV_ACC_0  = 16'hacff;
  localparam logic [15:0] FLASH_REG_RESET [NUM_FLASH_REGS] = '{
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_DATA, RST_DATA, RST_DATA, RST_DATA,
    RST_ZERO, RST_ZERO, RST_ZERO,
    RST_NV_ONES, RST_NV_ACC_0, RST_NV_ONES, RST_NV_ONES
  };

  // ==========================================================================
  // Peripheral extension bus map
  localparam logic [15:0] OFS_VOLATILE_UNPROTECT_0 = 16'heb50;
  localparam logic [15:0] RST_VOLATILE_UNPROTECT_0 = 16'h0000;

  // ==========================================================================
  // Extended special register space, identification words
  localparam logic [15:0] OFS_PROGRAMMING_VOLTAGE_ID = 16'hf078;
  localparam logic [15:0] OFS_MEMORY_TYPE_SIZE_ID    = 16'hf07a;
  localparam logic [15:0] OFS_CHIP_REVISION_ID       = 16'hf07c;
  localparam logic [15:0] OFS_MAKER_ID               = 16'hf07e;

  // Field positions and values
  localparam int          MEM_KIND_LSB      = 12;
  localparam int          MEM_SIZE_LSB      = 0;
  localparam int          REVISION_LSB      = 0;
  localparam int          REVISION_WIDTH    = 4;
  localparam int          SUPPLY_LSB        = 0;
  localparam int          EXTRA_SUPPLY_LSB  = 8;
  localparam logic [3:0]  MEM_KIND_NONE     = 4'h0;
  localparam logic [3:0]  MEM_KIND_MASK_ROM = 4'h1;
  localparam logic [3:0]  MEM_KIND_STD      = 4'h2;
  localparam logic [3:0]  MEM_KIND_HIGH     = 4'h3;
  localparam logic [11:0] MEM_SIZE_256K     = 12'h040;
  localparam logic [7:0]  SUPPLY_5V         = 8'h40;
  localparam logic [7:0]  EXTRA_SUPPLY_NONE = 8'h00;
  localparam logic [15:0] PRE_MEMORY_TYPE_SIZE_ID    = 16'hf040;
  localparam logic [15:0] PRE_PROGRAMMING_VOLTAGE_ID = 16'h0040;
  // Strap counter value after which the synchronised pin is no longer judged
  localparam logic [1:0]  STRAP_DONE_AGE    = 2'h3;

  // ==========================================================================
  // Access carriers
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        bitOp;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fid_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } fid_rsp_t;

endpackage : fid_pkg

// file: rtl/fid_flash_id_regs.sv
// Flash control registers, the volatile unprotection register and the identification words.
// Assumes single-cycle requests on three CPU-side access ports sharing ref_clk;
// the flash controller reports initialization done on the same clock.
`timescale 1ns/1ns

// Overview of operation
// - Flash registers answer on the memory bus; unprotection register on peripheral bus.
// - Only whole-word accesses; single-bit set or clear writes are refused.
// - Reset: data halves all ones; address, control, error, unprotection zero.
// - Reset: access protection 0 shows ACFF; other protection registers all ones.
// - Identification words sit at F078, F07A, F07C and F07E.
// - Identification words are read-only; writes leave them unchanged.
// - Identification fields hold final values only after flash initialization.
// - External-access pin high at reset means initialization already complete.
// - Memory-identification bits 15 and 14 go low once initialization completes.
// - Before completion memory word reads F040 and voltage word reads 0040.
// - Memory-size field is size in 4 KB units; 040 for 256 KB.
// - Memory-kind field encodes type; this device reports 3, high-performance flash.
// - Supply field is 20 times value over 256 volts; reads 40.
// - Extra-supply field reads 00, no separate programming supply.
// - Chip word holds revision in low bits, chip identifier in upper bits.
module fid_flash_id_regs #(
  parameter logic [11:0] CHIP_FIELD      = 12'h5a5,   // Arbitrary value
  parameter logic [3:0]  REVISION        = 4'h1,      // Arbitrary value
  parameter logic [15:0] MAKER_WORD      = 16'h0a53,  // Arbitrary value
  parameter logic [15:0] PRE_MAKER_WORD  = 16'h0a53,  // Arbitrary value
  parameter logic [15:0] PRE_CHIP_WORD   = 16'h5a51   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Pin and flash controller status
  input  wire logic                  externalAccessPin,
  input  wire logic                  flashInitDoneIn,
  // Internal memory bus
  input  wire fid_pkg::fid_req_t     memReq,
  output      fid_pkg::fid_rsp_t     memRsp,
  // Peripheral extension bus
  input  wire fid_pkg::fid_req_t     perReq,
  output      fid_pkg::fid_rsp_t     perRsp,
  // Extended special register space
  input  wire fid_pkg::fid_req_t     sfrReq,
  output      fid_pkg::fid_rsp_t     sfrRsp,
  // Register contents towards the flash controller
  output      logic [fid_pkg::NUM_FLASH_REGS-1:0][15:0] flashRegs,
  output      logic [15:0]           volatileUnprotect0,
  output      logic                  initDone
);

  localparam int REVISION_CHECK = $bits(REVISION);

  // Elaboration checks: the decode serves at most 16 words and a 4-bit revision
  if (REVISION_CHECK != fid_pkg::REVISION_WIDTH)
  begin : g_bad_revision
    $error("Revision width mismatch");
  end

  if (fid_pkg::NUM_FLASH_REGS > 16)
  begin : g_bad_reg_count
    $error("Flash register count exceeds the index width");
  end

  // ==========================================================================
  // Initialization tracking
  logic       extSync1;
  logic       extSync2;
  logic       strapTaken;
  logic [1:0] strapAge;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
    end
    else
    begin
      extSync1 <= externalAccessPin;
      extSync2 <= extSync1;
    end
  end

  // Counts edges until the synchroniser holds the pin level seen during reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      strapAge <= 2'h0;
    else if (!strapTaken)
      strapAge <= strapAge + 2'h1;
  end

  // The strap is judged at the one edge where the synchronised pin first stands
  assign strapTaken = (strapAge == fid_pkg::STRAP_DONE_AGE);

  // Sticky: once flash is ready it stays ready until the next reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      initDone <= 1'b0;
    else if (!initDone)
      initDone <= flashInitDoneIn | (extSync2 & ~strapTaken);
  end

  // ==========================================================================
  // Internal memory bus decode and registers
  logic                   memHit;
  logic [3:0]             memIdx;
  logic                   memWrOk;

  always_comb
  begin
    memHit = 1'b0;
    memIdx = 4'h0;
    for (int i = 0; i < fid_pkg::NUM_FLASH_REGS; i++)
    begin
      if (memReq.addr == fid_pkg::FLASH_REG_OFFSET[i])
      begin
        memHit = 1'b1;
        memIdx = 4'(i);
      end
    end
  end

  assign memWrOk = memReq.sel & memReq.wr & memHit & ~memReq.bitOp;

  generate
    for (genvar g = 0; g < fid_pkg::NUM_FLASH_REGS; g++)
    begin : g_flash_reg
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          flashRegs[g] <= fid_pkg::FLASH_REG_RESET[g];
        else if (memWrOk && memIdx == 4'(g))
          flashRegs[g] <= memReq.wdata;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      memRsp <= '0;
    else
    begin
      memRsp.ack   <= memReq.sel;
      memRsp.err   <= memReq.sel & (~memHit | (memReq.wr & memReq.bitOp));
      memRsp.rdata <= (memReq.sel && !memReq.wr && memHit) ? flashRegs[memIdx] : 16'h0000;
    end
  end

  // ==========================================================================
  // Peripheral extension bus
  logic perHit;

  assign perHit = (perReq.addr[15:0] == fid_pkg::OFS_VOLATILE_UNPROTECT_0)
                  && (perReq.addr[23:16] == 8'h00);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      volatileUnprotect0 <= fid_pkg::RST_VOLATILE_UNPROTECT_0;
    else if (perReq.sel && perReq.wr && perHit && !perReq.bitOp)
      volatileUnprotect0 <= perReq.wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      perRsp <= '0;
    else
    begin
      perRsp.ack   <= perReq.sel;
      perRsp.err   <= perReq.sel & (~perHit | (perReq.wr & perReq.bitOp));
      perRsp.rdata <= (perReq.sel && !perReq.wr && perHit) ? volatileUnprotect0 : 16'h0000;
    end
  end

  // ==========================================================================
  // Identification words
  logic [15:0] finalMemWord;
  logic [15:0] finalVoltWord;
  logic [15:0] finalChipWord;
  logic [15:0] idWord;
  logic        idHit;

  assign finalMemWord  = {fid_pkg::MEM_KIND_HIGH, fid_pkg::MEM_SIZE_256K};
  assign finalVoltWord = {fid_pkg::EXTRA_SUPPLY_NONE, fid_pkg::SUPPLY_5V};
  assign finalChipWord = {CHIP_FIELD, REVISION};

  always_comb
  begin
    idHit  = sfrReq.addr[23:16] == 8'h00;
    idWord = 16'h0000;
    case (sfrReq.addr[15:0])
      fid_pkg::OFS_PROGRAMMING_VOLTAGE_ID:
        idWord = initDone ? finalVoltWord : fid_pkg::PRE_PROGRAMMING_VOLTAGE_ID;
      fid_pkg::OFS_MEMORY_TYPE_SIZE_ID:
        idWord = initDone ? finalMemWord : fid_pkg::PRE_MEMORY_TYPE_SIZE_ID;
      fid_pkg::OFS_CHIP_REVISION_ID:
        idWord = initDone ? finalChipWord : PRE_CHIP_WORD;
      fid_pkg::OFS_MAKER_ID:
        idWord = initDone ? MAKER_WORD : PRE_MAKER_WORD;
      default:
        idHit = 1'b0;
    endcase
  end

  // Writes are answered with an error and change nothing
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfrRsp <= '0;
    else
    begin
      sfrRsp.ack   <= sfrReq.sel;
      sfrRsp.err   <= sfrReq.sel & (~idHit | sfrReq.wr);
      sfrRsp.rdata <= (sfrReq.sel && !sfrReq.wr && idHit) ? idWord : 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  logic afterReset;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      afterReset <= 1'b0;
    else
      afterReset <= 1'b1;
  end

  sequence s_mem_id_read;
    sfrReq.sel && !sfrReq.wr && sfrReq.addr == {8'h00, fid_pkg::OFS_MEMORY_TYPE_SIZE_ID};
  endsequence

  sequence s_volt_id_read;
    sfrReq.sel && !sfrReq.wr && sfrReq.addr == {8'h00, fid_pkg::OFS_PROGRAMMING_VOLTAGE_ID};
  endsequence

  sequence s_chip_id_read;
    sfrReq.sel && !sfrReq.wr && sfrReq.addr == {8'h00, fid_pkg::OFS_CHIP_REVISION_ID};
  endsequence

  sequence s_maker_id_read;
    sfrReq.sel && !sfrReq.wr && sfrReq.addr == {8'h00, fid_pkg::OFS_MAKER_ID};
  endsequence

  property p_mem_unmapped_err;
    @(posedge ref_clk) disable iff (!rst_n)
      memReq.sel && !memHit |=> memRsp.ack && memRsp.err && memRsp.rdata == 16'h0000;
  endproperty
  a_mem_unmapped_err: assert property (p_mem_unmapped_err) else $error("Miss not refused");

  property p_bitop_no_write;
    @(posedge ref_clk) disable iff (!rst_n)
      memReq.sel && memReq.wr && memReq.bitOp |=> $stable(flashRegs) && memRsp.err;
  endproperty
  a_bitop_no_write: assert property (p_bitop_no_write) else $error("Bit write landed");

  property p_reset_values;
    @(posedge ref_clk) disable iff (!rst_n)
      !afterReset |-> flashRegs[fid_pkg::IDX_DATA_0_LOW] == 16'hffff
        && flashRegs[fid_pkg::IDX_CONTROL_0_LOW] == 16'h0000
        && flashRegs[fid_pkg::IDX_ERROR_FLAGS] == 16'h0000 && volatileUnprotect0 == 16'h0000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Wrong reset value");

  property p_nv_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      !afterReset |-> flashRegs[fid_pkg::IDX_NV_ACCESS_PROT_0] == 16'hacff
        && flashRegs[11] == 16'hffff && flashRegs[14] == 16'hffff;
  endproperty
  a_nv_reset: assert property (p_nv_reset) else $error("Wrong protection reset value");

  property p_id_write_refused;
    @(posedge ref_clk) disable iff (!rst_n)
      sfrReq.sel && sfrReq.wr |=> sfrRsp.ack && sfrRsp.err;
  endproperty
  a_id_write_refused: assert property (p_id_write_refused) else $error("Id write accepted");

  property p_pre_init_defaults;
    @(posedge ref_clk) disable iff (!rst_n)
      !initDone ##0 s_mem_id_read |=> sfrRsp.rdata == 16'hf040;
  endproperty
  a_pre_init_defaults: assert property (p_pre_init_defaults) else $error("Bad default");

  property p_pre_init_volt;
    @(posedge ref_clk) disable iff (!rst_n)
      s_volt_id_read |=> sfrRsp.rdata == 16'h0040;
  endproperty
  a_pre_init_volt: assert property (p_pre_init_volt) else $error("Bad voltage word");

  property p_final_mem_word;
    @(posedge ref_clk) disable iff (!rst_n)
      initDone ##0 s_mem_id_read |=> sfrRsp.rdata[15:14] == 2'b00 && sfrRsp.rdata == 16'h3040;
  endproperty
  a_final_mem_word: assert property (p_final_mem_word) else $error("Bad final memory word");

  property p_strap_done;
    @(posedge ref_clk) disable iff (!rst_n)
      extSync2 && !strapTaken |=> initDone;
  endproperty
  a_strap_done: assert property (p_strap_done) else $error("Strap did not mark ready");

  property p_done_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      initDone |=> initDone [*2];
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("Ready flag dropped");

  property p_mem_ack;
    @(posedge ref_clk) disable iff (!rst_n)
      memReq.sel |=> memRsp.ack;
  endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("No memory answer");

  property p_mem_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !memReq.sel |=> !memRsp.ack && !memRsp.err && memRsp.rdata == 16'h0000;
  endproperty
  a_mem_idle: assert property (p_mem_idle) else $error("Answer without request");

  property p_mem_write_ok;
    @(posedge ref_clk) disable iff (!rst_n)
      memReq.sel && memReq.wr && !memReq.bitOp && memHit |=> memRsp.ack && !memRsp.err;
  endproperty
  a_mem_write_ok: assert property (p_mem_write_ok) else $error("Word write refused");

  property p_per_miss_err;
    @(posedge ref_clk) disable iff (!rst_n)
      perReq.sel && !perHit |=> perRsp.ack && perRsp.err && perRsp.rdata == 16'h0000;
  endproperty
  a_per_miss_err: assert property (p_per_miss_err) else $error("Peripheral miss");

  property p_per_write_lands;
    @(posedge ref_clk) disable iff (!rst_n)
      perReq.sel && perReq.wr && !perReq.bitOp && perHit
        |=> volatileUnprotect0 == $past(perReq.wdata);
  endproperty
  a_per_write_lands: assert property (p_per_write_lands) else $error("Write lost");

  property p_per_bit_write;
    @(posedge ref_clk) disable iff (!rst_n)
      perReq.sel && perReq.wr && perReq.bitOp |=> $stable(volatileUnprotect0) && perRsp.err;
  endproperty
  a_per_bit_write: assert property (p_per_bit_write) else $error("Bit write landed");

  property p_id_read_ok;
    @(posedge ref_clk) disable iff (!rst_n)
      sfrReq.sel && !sfrReq.wr && idHit |=> sfrRsp.ack && !sfrRsp.err;
  endproperty
  a_id_read_ok: assert property (p_id_read_ok) else $error("Id read refused");

  property p_id_miss_err;
    @(posedge ref_clk) disable iff (!rst_n)
      sfrReq.sel && !idHit |=> sfrRsp.ack && sfrRsp.err && sfrRsp.rdata == 16'h0000;
  endproperty
  a_id_miss_err: assert property (p_id_miss_err) else $error("Id miss accepted");

  property p_final_volt_word;
    @(posedge ref_clk) disable iff (!rst_n)
      initDone ##0 s_volt_id_read
        |=> sfrRsp.rdata[15:8] == 8'h00 && sfrRsp.rdata[7:0] == 8'h40;
  endproperty
  a_final_volt_word: assert property (p_final_volt_word) else $error("Bad supply word");

  property p_final_chip_word;
    @(posedge ref_clk) disable iff (!rst_n)
      initDone ##0 s_chip_id_read
        |=> sfrRsp.rdata[3:0] == REVISION && sfrRsp.rdata[15:4] == CHIP_FIELD;
  endproperty
  a_final_chip_word: assert property (p_final_chip_word) else $error("Bad chip word");

  property p_pre_chip_word;
    @(posedge ref_clk) disable iff (!rst_n)
      !initDone ##0 s_chip_id_read |=> sfrRsp.rdata == PRE_CHIP_WORD;
  endproperty
  a_pre_chip_word: assert property (p_pre_chip_word) else $error("Bad default chip");

  property p_maker_word;
    @(posedge ref_clk) disable iff (!rst_n)
      s_maker_id_read |=> sfrRsp.rdata == ($past(initDone) ? MAKER_WORD : PRE_MAKER_WORD);
  endproperty
  a_maker_word: assert property (p_maker_word) else $error("Bad maker word");

  property p_done_from_flash;
    @(posedge ref_clk) disable iff (!rst_n)
      flashInitDoneIn |=> initDone;
  endproperty
  a_done_from_flash: assert property (p_done_from_flash) else $error("Flash ready ignored");

  property p_no_early_done;
    @(posedge ref_clk) disable iff (!rst_n)
      !initDone && !flashInitDoneIn && !(extSync2 && !strapTaken) |=> !initDone;
  endproperty
  a_no_early_done: assert property (p_no_early_done) else $error("Ready without cause");

endmodule : fid_flash_id_regs

// file: sim/fid_cpu_model.sv
// CPU-side partner: single-word accesses on the three request ports.
// Assumes requests launch at the falling edge and answers come within three cycles.
`timescale 1ns/1ns
module fid_cpu_model (
  // Clock
  input  wire logic              ref_clk,
  // Requests
  output fid_pkg::fid_req_t      memReq,
  output fid_pkg::fid_req_t      perReq,
  output fid_pkg::fid_req_t      sfrReq,
  // Answers
  input  wire fid_pkg::fid_rsp_t memRsp,
  input  wire fid_pkg::fid_rsp_t perRsp,
  input  wire fid_pkg::fid_rsp_t sfrRsp
);
  integer seed = 32'h2bc0;

  // ==========================================================================
  // Idle lines carry a changing pattern so a stale value never looks valid
  function automatic fid_pkg::fid_req_t idleReq();
    idleReq = '0;
    idleReq.wr = 1'($random(seed));
    idleReq.bitOp = 1'($random(seed));
    idleReq.addr = 24'($random(seed));
    idleReq.wdata = 16'($random(seed));
  endfunction : idleReq

  initial
  begin
    memReq = idleReq();
    perReq = idleReq();
    sfrReq = idleReq();
  end

  task automatic drive(input int port, input fid_pkg::fid_req_t r);
    if (port == 0) memReq = r;
    else if (port == 1) perReq = r;
    else sfrReq = r;
  endtask : drive

  // ==========================================================================
  // One access: sel for one cycle, then wait a bounded time for ack
  task automatic access(input int port, input logic wr, input logic bitOp,
                        input logic [23:0] addr, input logic [15:0] wdata,
                        output fid_pkg::fid_rsp_t rsp);
    fid_pkg::fid_req_t r;
    int n;
    r = '{sel: 1'b1, wr: wr, bitOp: bitOp, addr: addr, wdata: wdata};
    n = 0;
    @(negedge ref_clk);
    drive(port, r);
    @(negedge ref_clk);
    drive(port, idleReq());
    rsp = (port == 0) ? memRsp : (port == 1) ? perRsp : sfrRsp;
    while (rsp.ack !== 1'b1 && n < 3)
    begin
      @(negedge ref_clk);
      rsp = (port == 0) ? memRsp : (port == 1) ? perRsp : sfrRsp;
      n++;
    end
  endtask : access

  // Identification is trusted only once bits 15 and 14 read low
  task automatic pollInit(output int polls, output fid_pkg::fid_rsp_t rsp);
    polls = 0;
    do
    begin
      access(2, 1'b0, 1'b0, {8'h00, fid_pkg::OFS_MEMORY_TYPE_SIZE_ID}, 16'h0000, rsp);
      polls++;
    end
    while (rsp.rdata[15:14] !== 2'b00 && polls < 20);
  endtask : pollInit
endmodule : fid_cpu_model

// file: sim/flash_ctrl_and_id_register_map_bench.sv
// Self-checking bench for the flash control and identification register bank.
// Assumes the CPU partner model and the design package are compiled first.
`timescale 1ns/1ns
module flash_ctrl_and_id_register_map_bench;
  localparam logic [11:0] CHIP      = 12'h5a5;  // Arbitrary value
  localparam logic [3:0]  REV       = 4'h2;     // Arbitrary value
  localparam logic [15:0] MAKER     = 16'h0a53; // Arbitrary value
  localparam logic [15:0] PRE_MAKER = 16'h3c3c; // Arbitrary value
  localparam logic [15:0] PRE_CHIP  = 16'h5a50; // Arbitrary value
  localparam int          NREG      = fid_pkg::NUM_FLASH_REGS;
  logic                   ref_clk, rst_n, externalAccessPin, flashInitDoneIn;
  fid_pkg::fid_req_t      memReq, perReq, sfrReq;
  fid_pkg::fid_rsp_t      memRsp, perRsp, sfrRsp, rsp;
  logic [NREG-1:0][15:0]  flashRegs;
  logic [15:0]            volatileUnprotect0, vu, w;
  logic                   initDone;
  logic [15:0]            mirror [NREG];
  int                     errTotal = 0, testsRun = 0, polls, a;
  integer                 seed = 32'h2bc0;

  fid_flash_id_regs #(.CHIP_FIELD(CHIP), .REVISION(REV), .MAKER_WORD(MAKER),
    .PRE_MAKER_WORD(PRE_MAKER), .PRE_CHIP_WORD(PRE_CHIP)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .externalAccessPin(externalAccessPin),
    .flashInitDoneIn(flashInitDoneIn), .memReq(memReq), .memRsp(memRsp),
    .perReq(perReq), .perRsp(perRsp), .sfrReq(sfrReq), .sfrRsp(sfrRsp),
    .flashRegs(flashRegs), .volatileUnprotect0(volatileUnprotect0), .initDone(initDone));

  fid_cpu_model cpu (.ref_clk(ref_clk), .memReq(memReq), .perReq(perReq), .sfrReq(sfrReq),
    .memRsp(memRsp), .perRsp(perRsp), .sfrRsp(sfrRsp));

  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (errTotal == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Reference model reset: data halves and nv words ones, nv access 0 acff
  task automatic resetModel();
    for (int i = 0; i < NREG; i++)
      mirror[i] = (i == 12) ? 16'hacff : ((i >= 4 && i <= 7) || i >= 11) ? 16'hffff : 16'h0;
    vu = 16'h0000;
  endtask : resetModel

  task automatic xfer(input int port, input logic wr, input logic bop, input logic [23:0] ad,
                      input logic [15:0] wd, input logic expErr, input logic [15:0] expData);
    cpu.access(port, wr, bop, ad, wd, rsp);
    check("ack", {15'h0, rsp.ack}, 16'h1);
    check("err", {15'h0, rsp.err}, {15'h0, expErr});
    if (!wr || expErr)
      check("rdata", rsp.rdata, expData);
  endtask : xfer

  task automatic idReads(input logic done);
    xfer(2, 0, 0, 24'h00f078, 0, 0, {8'h00, 8'h40});
    xfer(2, 0, 0, 24'h00f07a, 0, 0, done ? {4'h3, 12'h040} : 16'hf040);
    xfer(2, 0, 0, 24'h00f07c, 0, 0, done ? {CHIP, REV} : PRE_CHIP);
    xfer(2, 0, 0, 24'h00f07e, 0, 0, done ? MAKER : PRE_MAKER);
  endtask : idReads

  task automatic checkState();
    for (int i = 0; i < NREG; i++)
      check("flashRegs", flashRegs[i], mirror[i]);
    check("volatileUnprotect0", volatileUnprotect0, vu);
  endtask : checkState

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial
  begin
    #2000000;
    errTotal++;
    conclude();
  end

  initial
  begin
    rst_n = 1'b0;
    externalAccessPin = 1'b0;
    flashInitDoneIn = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    resetModel();
    checkState();
    for (int i = 0; i < NREG; i++)
      xfer(0, 0, 0, fid_pkg::FLASH_REG_OFFSET[i], 0, 0, mirror[i]);
    xfer(1, 0, 0, 24'h00eb50, 0, 0, vu);
    check("initDone", {15'h0, initDone}, 16'h0);
    idReads(1'b0);
    for (int i = 0; i < 4; i++)
      xfer(2, 1, 0, 24'h00f078 + 24'(2 * i), 16'(i), 1, 16'h0);
    idReads(1'b0);
    repeat (40)
    begin
      a = {$random(seed)} % NREG;
      w = 16'($random(seed));
      xfer(0, 1, 0, fid_pkg::FLASH_REG_OFFSET[a], w, 0, 16'h0);
      mirror[a] = w;
      xfer(0, 0, 0, fid_pkg::FLASH_REG_OFFSET[a], 0, 0, mirror[a]);
      xfer(0, 1, 1, fid_pkg::FLASH_REG_OFFSET[a], ~w, 1, 16'h0);
      xfer(1, 1, 0, 24'h00eb50, ~w, 0, 16'h0);
      vu = ~w;
      xfer(1, 1, 1, 24'h00eb50, w, 1, 16'h0);
      checkState();
    end
    xfer(0, 0, 0, 24'h00eb50, 0, 1, 16'h0);
    xfer(1, 0, 0, 24'h00eb52, 0, 1, 16'h0);
    xfer(0, 0, 0, 24'h080016, 0, 1, 16'h0);
    xfer(2, 0, 0, 24'h00f080, 0, 1, 16'h0);
    flashInitDoneIn = 1'b1;
    cpu.pollInit(polls, rsp);
    check("pollBits", {14'h0, rsp.rdata[15:14]}, 16'h0);
    @(negedge ref_clk);
    flashInitDoneIn = 1'b0;
    check("initDone", {15'h0, initDone}, 16'h1);
    idReads(1'b1);
    rst_n = 1'b0;
    externalAccessPin = 1'b1;
    repeat (5) @(negedge ref_clk);
    resetModel();
    checkState();
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("initDone", {15'h0, initDone}, 16'h1);
    idReads(1'b1);
    conclude();
  end
endmodule : flash_ctrl_and_id_register_map_bench
